// ---- bus_controller.sv ----
// system controller model: sends command text and collects response characters
`timescale 1ns/10ps
module bus_controller (
  // clock
  input wire logic clk_i,
  // response side
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // command side
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  // stall mode
  input wire logic slow_i
);
  logic [7:0] resp_q[$];
  logic [7:0] stall = 8'h5A;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end

  // a character is taken only at an edge where ready is high
  always @(posedge clk_i) begin
    stall <= {stall[6:0], stall[7] ^ stall[5] ^ stall[4] ^ stall[3]};
    tx_ready_o <= !slow_i || stall[0];
    if (tx_valid_i && tx_ready_o) begin
      resp_q.push_back(tx_data_i);
    end
  end

  // one character per edge; the data line shows garbage once released
  task automatic send_cmd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= s[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule

// ---- header_match.sv ----
// matches one header word against status subsystem mnemonics
`timescale 1ns/10ps
module header_match
  import status_pkg::*;
(
  // path so far and the current word
  input wire logic [7:0] node_i,
  input wire logic [7:0] word_i,
  input wire logic [2:0] wlen_i,
  // match result
  output logic [7:0] node_o,
  output logic bad_o
);
  // words are reduced to their first letters; long forms share them, case folded by caller
  // an E word whose second letter is N arrives as n, so enable and event stay apart
  // node codes: 01 status, 02 status:oper, 03 status:ques, 1x condition, 20/21 enable, 24/25 event, 3x leaves
  always_comb begin
    node_o = 8'h00;
    bad_o = 1'b0;
    case (node_i)
      8'h00: begin
        if (word_i == "S") node_o = 8'h01;
        else bad_o = 1'b1;
      end
      8'h01: begin
        if (word_i == "O") node_o = 8'h02;
        else if (word_i == "Q") node_o = 8'h03;
        else if (word_i == "P") node_o = 8'h30;
        else bad_o = 1'b1;
      end
      8'h02, 8'h03: begin
        if (word_i == "C") node_o = node_i + 8'h0E;
        else if (word_i == "n") node_o = node_i + 8'h1E;
        else if (word_i == "E" && wlen_i != 3'd0) node_o = node_i + 8'h22;
        else if (word_i == "F" && node_i == 8'h03) node_o = 8'h31;
        else bad_o = 1'b1;
      end
      default: bad_o = 1'b1;
    endcase
  end
endmodule

// ---- status_pkg.sv ----
// constants and types shared by the status reporting block
// How it works
// - summary bit needs event and enable both
// - enabled summary bit raises service request
// - status byte bits 0-2 read zero
// - bit 3 summarizes enabled questionable events
// - bit 4 follows output buffer occupancy
// - bit 5 summarizes enabled standard events
// - bit 7 summarizes enabled operation events
// - headers any case, long/short, optional parts
// - trailing question mark selects query form
// - stray parameter dropped, warning bit 14
// - command error answers NAK, sets error bit 5
// - operation condition query returns decimal
// - operation enable write 0-32767, query decimal
// - operation event query returns decimal
// - questionable condition query returns decimal
// - questionable enable write 0-32767, query decimal
// - questionable event query returns decimal
// - resistance fault query returns hexadecimal byte
// - resistance fault bits set on fault
// - preset clears both enable registers
// - operation bits; power-on cleared by read/clear
package status_pkg;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam int OPER_CAL_BIT = 0;
  localparam int OPER_RANGE_BIT = 2;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_EOC_BIT = 8;
  localparam int OPER_PON_BIT = 9;
  localparam int QUES_WARN_BIT = 14;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam logic [15:0] ENABLE_MAX = 16'h7FFF;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [7:0] CHAR_ACK = 8'h06;
  localparam logic [7:0] CHAR_NAK = 8'h15;
  localparam logic [7:0] CHAR_NL = 8'h0A;
  localparam logic [7:0] CHAR_QM = 8'h3F;
  localparam logic [7:0] CHAR_COLON = 8'h3A;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_SEMI = 8'h3B;
  localparam int MAX_RESP = 6;

  // decoded status commands
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_OPER_COND = 4'h1,
    CMD_OPER_ENAB = 4'h2,
    CMD_OPER_EVEN = 4'h3,
    CMD_QUES_COND = 4'h4,
    CMD_QUES_ENAB = 4'h5,
    CMD_QUES_EVEN = 4'h6,
    CMD_QUES_FRES = 4'h7,
    CMD_PRESET = 4'h8,
    CMD_BAD = 4'hF
  } cmd_t;

  typedef enum logic [1:0] {
    ST_HEADER = 2'b00,
    ST_PARAM = 2'b01,
    ST_SKIP = 2'b10,
    ST_SEND = 2'b11
  } parse_state_t;

  // one decoded header from the header matcher
  typedef struct packed {
    cmd_t cmd;
    logic query;
  } decoded_t;

  typedef struct packed {
    parse_state_t st;
    logic [7:0] node;
    logic [7:0] word;
    logic [2:0] wlen;
    logic query;
    logic has_param;
    logic [16:0] param;
    logic param_bad;
    decoded_t dec;
    logic [15:0] oper_cond;
    logic [15:0] oper_enab;
    logic [15:0] oper_even;
    logic [15:0] ques_cond;
    logic [15:0] ques_enab;
    logic [15:0] ques_even;
    logic [7:0] fres;
    logic [7:0] esr;
    logic pon_pending;
    logic [7:0][7:0] resp;
    logic [2:0] resp_len;
    logic [2:0] resp_idx;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [7:0] stb;
    logic srq;
  } state_t;
endpackage

// ---- status_reporting.sv ----
// status byte, status registers and status command interpreter
`timescale 1ns/10ps
module status_reporting
  import status_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // command characters from the bus
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // response characters to the bus
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // condition inputs from the instrument
  input wire logic [15:0] oper_cond_i,
  input wire logic [15:0] ques_cond_i,
  input wire logic [7:0] fres_fault_i,
  input wire logic [7:0] esr_event_i,
  input wire logic [7:0] esr_enable_i,
  input wire logic [7:0] srq_enable_i,
  input wire logic power_on_flag_i,
  input wire logic clear_status_i,
  input wire logic out_buf_busy_i,
  // status outputs
  output logic [7:0] summary_status_byte_o,
  output logic service_request_o,
  output logic [7:0] std_event_o
);
  state_t s, next_s;
  logic [7:0] up_char;
  logic [7:0] match_node;
  logic match_bad;
  logic is_letter;
  logic is_digit;
  logic is_hex_q;
  logic [15:0] value;
  logic [16:0] digit_acc;
  logic [7:0][7:0] text;
  logic [2:0] text_len;
  logic [15:0] rem;
  logic [15:0] oper_rise;
  logic [15:0] ques_rise;
  logic [3:0] nib;

  // header case folding
  // upper and lower case accepted
  assign up_char = (rx_data_i >= "a" && rx_data_i <= "z") ? rx_data_i - 8'h20 : rx_data_i;
  assign is_letter = (up_char >= "A" && up_char <= "Z");
  assign is_digit = (rx_data_i >= "0" && rx_data_i <= "9");
  assign digit_acc = 17'(s.param * 17'd10) + 17'(rx_data_i - "0");
  assign is_hex_q = (s.dec.cmd == CMD_QUES_FRES);

  header_match u_match (
    .node_i(s.node),
    .word_i(s.word),
    .wlen_i(s.wlen),
    .node_o(match_node),
    .bad_o(match_bad)
  );

  assign oper_rise = oper_cond_i & ~s.oper_cond;
  assign ques_rise = ques_cond_i & ~s.ques_cond;

  always_comb begin
    value = 16'h0000;
    rem = 16'h0000;
    text = '0;
    text_len = 3'd0;
    nib = 4'h0;
    case (s.dec.cmd)
      CMD_OPER_COND: value = s.oper_cond;
      CMD_OPER_ENAB: value = s.oper_enab;
      CMD_OPER_EVEN: value = s.oper_even;
      CMD_QUES_COND: value = s.ques_cond;
      CMD_QUES_ENAB: value = s.ques_enab;
      CMD_QUES_EVEN: value = s.ques_even;
      CMD_QUES_FRES: value = {8'h00, s.fres};
      default: value = 16'h0000;
    endcase
    // hex formatting of the fault byte
    if (is_hex_q) begin
      for (int i = 0; i < 2; i++) begin
        nib = value[4*i +: 4];
        text[i] = (nib < 4'hA) ? 8'("0") + 8'(nib) : 8'("A") + 8'(nib - 4'hA);
      end
      text_len = 3'd2;
    end else begin
      // decimal digits, least significant first
      rem = value;
      for (int i = 0; i < 5; i++) begin
        text[i] = 8'("0") + 8'(rem % 16'd10);
        if (rem != 16'h0000 || i == 0) text_len = 3'(i + 1);
        rem = rem / 16'd10;
      end
    end
  end

  always_comb begin
    next_s = s;
    next_s.tx_valid = 1'b0;
    // fault bits set when a fault occurs
    next_s.fres = s.fres | fres_fault_i;
    next_s.oper_cond = oper_cond_i;
    next_s.ques_cond = ques_cond_i;
    next_s.oper_even = s.oper_even | oper_rise;
    next_s.ques_even = s.ques_even | ques_rise;
    next_s.esr = s.esr | esr_event_i;
    if (clear_status_i) begin
      next_s.oper_even = oper_rise;
      next_s.ques_even = ques_rise;
      next_s.esr = esr_event_i;
      next_s.fres = fres_fault_i;
    end
    case (s.st)
      ST_HEADER: if (rx_valid_i) begin
        if (is_letter) begin
          // short form kept, long-form tail ignored
          if (s.wlen == 3'd0) next_s.word = up_char;
          // second letter N tells enable apart from event
          if (s.wlen == 3'd1 && s.word == "E" && up_char == "N") next_s.word = "n";
          if (s.wlen != 3'd7) next_s.wlen = s.wlen + 3'd1;
        end else if (rx_data_i == "[" || rx_data_i == "]") begin
          next_s.wlen = s.wlen;
        end else if (rx_data_i == CHAR_COLON || rx_data_i == CHAR_QM || rx_data_i == CHAR_SPACE ||
                     rx_data_i == CHAR_NL || rx_data_i == CHAR_SEMI) begin
          if (s.wlen != 3'd0) begin
            next_s.node = match_bad ? 8'hFF : match_node;
            next_s.wlen = 3'd0;
          end
          // question mark marks the query form
          if (rx_data_i == CHAR_QM) next_s.query = 1'b1;
          if (rx_data_i == CHAR_SPACE) next_s.st = ST_PARAM;
          if (rx_data_i == CHAR_NL || rx_data_i == CHAR_SEMI) next_s.st = ST_SEND;
        end else begin
          next_s.node = 8'hFF;
        end
      end
      ST_PARAM: if (rx_valid_i) begin
        if (is_digit) begin
          next_s.has_param = 1'b1;
          next_s.param = digit_acc;
          if (digit_acc > 17'(ENABLE_MAX)) next_s.param_bad = 1'b1;
        end else if (rx_data_i == CHAR_NL || rx_data_i == CHAR_SEMI) begin
          next_s.st = ST_SEND;
        end else if (rx_data_i != CHAR_SPACE) begin
          next_s.has_param = 1'b1;
          next_s.param_bad = 1'b1;
        end
      end
      ST_SEND: begin
        // final decode of the collected header
        next_s.dec.query = s.query;
        case (s.node)
          8'h10: next_s.dec.cmd = CMD_OPER_COND;
          8'h11: next_s.dec.cmd = CMD_QUES_COND;
          8'h20: next_s.dec.cmd = CMD_OPER_ENAB;
          8'h21: next_s.dec.cmd = CMD_QUES_ENAB;
          8'h24, 8'h02: next_s.dec.cmd = CMD_OPER_EVEN;
          8'h25, 8'h03: next_s.dec.cmd = CMD_QUES_EVEN;
          8'h31: next_s.dec.cmd = CMD_QUES_FRES;
          8'h30: next_s.dec.cmd = CMD_PRESET;
          default: next_s.dec.cmd = CMD_BAD;
        endcase
        next_s.st = ST_SKIP;
      end
      ST_SKIP: begin
        // execute decoded command and build the answer
        next_s.resp_idx = 3'd0;
        next_s.resp_len = 3'd1;
        next_s.resp[0] = CHAR_ACK;
        if (s.dec.cmd == CMD_BAD ||
            ((s.dec.cmd == CMD_OPER_ENAB || s.dec.cmd == CMD_QUES_ENAB) && !s.dec.query &&
             (s.param_bad || !s.has_param)) ||
            ((s.dec.cmd == CMD_PRESET) && s.dec.query)) begin
          next_s.resp[0] = CHAR_NAK;
          next_s.esr[ESR_CMD_ERR_BIT] = 1'b1;
        end else if (s.dec.query) begin
          for (int i = 0; i < 5; i++) begin
            if (3'(i) < text_len) next_s.resp[3'(i) + 3'd0] = text[text_len - 3'(i) - 3'd1];
          end
          next_s.resp[text_len] = CHAR_NL;
          next_s.resp_len = text_len + 3'd1;
          if (s.dec.cmd == CMD_OPER_EVEN) next_s.oper_even = oper_rise;
          if (s.dec.cmd == CMD_QUES_EVEN) next_s.ques_even = ques_rise;
          // stray parameter on a query ignored with warning
          if (s.has_param) next_s.ques_even[QUES_WARN_BIT] = 1'b1;
        end else begin
          case (s.dec.cmd)
            // enable written from the decimal parameter
            CMD_OPER_ENAB: next_s.oper_enab = s.param[15:0];
            // enable written from the decimal parameter
            CMD_QUES_ENAB: next_s.ques_enab = s.param[15:0];
            CMD_PRESET: begin
              next_s.oper_enab = REG16_RESET;
              next_s.ques_enab = REG16_RESET;
              if (s.has_param) next_s.ques_even[QUES_WARN_BIT] = 1'b1;
            end
            default: begin
              // query-only header sent as a setting
              next_s.resp[0] = CHAR_NAK;
              next_s.esr[ESR_CMD_ERR_BIT] = 1'b1;
            end
          endcase
        end
        next_s.node = 8'h00;
        next_s.word = 8'h00;
        next_s.wlen = 3'd0;
        next_s.query = 1'b0;
        next_s.has_param = 1'b0;
        next_s.param = 17'h00000;
        next_s.param_bad = 1'b0;
        next_s.st = ST_HEADER;
        next_s.tx_valid = 1'b0;
      end
      default: next_s.st = ST_HEADER;
    endcase
    // power-on flag latched until read or cleared; a new flag beats the clear
    if (power_on_flag_i) next_s.oper_even[OPER_PON_BIT] = 1'b1;
    // response streaming runs beside header parsing
    if (s.resp_idx < s.resp_len && s.st != ST_SKIP) begin
      if (!s.tx_valid || tx_ready_i) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = s.resp[s.resp_idx];
        next_s.resp_idx = s.resp_idx + 3'd1;
      end else begin
        next_s.tx_valid = 1'b1;
      end
    end else if (s.tx_valid && !tx_ready_i) begin
      next_s.tx_valid = 1'b1;
    end
    next_s.stb = 8'h00;
    next_s.stb[STB_QUES_BIT] = |(next_s.ques_even & next_s.ques_enab);
    next_s.stb[STB_MAV_BIT] = out_buf_busy_i || (next_s.resp_idx < next_s.resp_len) || next_s.tx_valid;
    next_s.stb[STB_ESB_BIT] = |(next_s.esr & esr_enable_i);
    next_s.stb[STB_OPER_BIT] = |(next_s.oper_even & next_s.oper_enab);
    next_s.srq = |(next_s.stb & srq_enable_i & ~(8'h01 << STB_RQS_BIT));
    next_s.stb[STB_RQS_BIT] = next_s.srq;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tx_valid_o = s.tx_valid;
  assign tx_data_o = s.tx_data;
  assign summary_status_byte_o = s.stb;
  assign service_request_o = s.srq;
  assign std_event_o = s.esr;

  property p_low_zero;
    @(posedge clk_i) disable iff (sys_rst_i) s.stb[2:0] == 3'b000;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("stb low bits set");
  property p_ques_sum;
    @(posedge clk_i) disable iff (sys_rst_i) s.stb[STB_QUES_BIT] == |(s.ques_even & s.ques_enab);
  endproperty
  a_ques_sum: assert property (p_ques_sum) else $error("ques summary wrong");
  property p_oper_sum;
    @(posedge clk_i) disable iff (sys_rst_i) s.stb[STB_OPER_BIT] == |(s.oper_even & s.oper_enab);
  endproperty
  a_oper_sum: assert property (p_oper_sum) else $error("oper summary wrong");
  property p_srq;
    @(posedge clk_i) disable iff (sys_rst_i) service_request_o |-> |(s.stb & ~8'h40) ;
  endproperty
  a_srq: assert property (p_srq) else $error("srq without summary");
  property p_preset;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s.st == ST_SKIP && s.dec.cmd == CMD_PRESET && !s.dec.query) |=> s.oper_enab == 16'h0000 && s.ques_enab == 16'h0000;
  endproperty
  a_preset: assert property (p_preset) else $error("preset failed");
  property p_nak;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s.st == ST_SKIP && s.dec.cmd == CMD_BAD) |=> s.resp[0] == CHAR_NAK && s.esr[ESR_CMD_ERR_BIT];
  endproperty
  a_nak: assert property (p_nak) else $error("no nak on error");
  property p_fres;
    @(posedge clk_i) disable iff (sys_rst_i) (fres_fault_i != 8'h00 && !clear_status_i) |=> (s.fres & $past(fres_fault_i)) == $past(fres_fault_i);
  endproperty
  a_fres: assert property (p_fres) else $error("fault bit not set");
  property p_rise;
    @(posedge clk_i) disable iff (sys_rst_i)
      (oper_rise != 16'h0000) |=> (s.oper_even & $past(oper_rise)) == $past(oper_rise);
  endproperty
  a_rise: assert property (p_rise) else $error("event not latched");
endmodule

// ---- status_reporting_tb_top.sv ----
// self-checking bench for the status reporting block
`timescale 1ns/10ps
module status_reporting_tb_top
  import status_pkg::*;
();
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rx_valid, tx_ready, tx_valid, srq, power_on_flag = 1'b0, cls = 1'b0, busy = 1'b0, slow = 1'b0;
  logic [7:0] rx_data, tx_data, stb, std_ev, fres = 8'h00, esr_ev = 8'h00, esr_en = 8'h00, srq_en = 8'h00;
  logic [15:0] oper_cond = 16'h0000, ques_cond = 16'h0000, rnd = 16'h0055, v;
  int error_cnt = 0;
  int compares = 0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  status_reporting u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .oper_cond_i(oper_cond),
    .ques_cond_i(ques_cond), .fres_fault_i(fres), .esr_event_i(esr_ev), .esr_enable_i(esr_en),
    .srq_enable_i(srq_en), .power_on_flag_i(power_on_flag), .clear_status_i(cls), .out_buf_busy_i(busy),
    .summary_status_byte_o(stb), .service_request_o(srq), .std_event_o(std_ev));

  bus_controller u_ctrl (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .slow_i(slow));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic string dec(input logic [15:0] x);
    return $sformatf("%0d\n", x);
  endfunction
  function automatic string chr(input logic [7:0] c);
    string s;
    s = " ";
    s[0] = c;
    return s;
  endfunction

  task automatic tally_and_finish;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // waits for the whole answer under a bound, then compares it character by character
  task automatic chk_resp(input string name, input string exp);
    int n;
    bit bad;
    n = 0;
    bad = 1'b0;
    while (u_ctrl.resp_q.size() < exp.len() && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
    compares++;
    if (u_ctrl.resp_q.size() != exp.len()) bad = 1'b1;
    for (int i = 0; i < exp.len() && !bad; i++) begin
      if (u_ctrl.resp_q[i] !== exp[i]) bad = 1'b1;
    end
    if (bad) begin
      error_cnt++;
      $display("MISMATCH %s expected %p seen %p", name, exp, u_ctrl.resp_q);
    end
    u_ctrl.resp_q.delete();
  endtask
  task automatic cmd(input string name, input string s, input string exp);
    u_ctrl.send_cmd(s);
    chk_resp(name, exp);
  endtask
  task automatic pulse_cls;
    @(posedge clk_i);
    cls <= 1'b1;
    @(posedge clk_i);
    cls <= 1'b0;
    settle;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle;
    // status byte and standard event register zero after reset
    chk8("stb reset", 8'h00, stb);
    chk8("esr reset", 8'h00, std_ev);
    $display("test reset done");

    rnd = lfsr_next(rnd);
    oper_cond <= rnd;
    settle;
    cmd("oper cond", "S:O:C?\n", dec(rnd));
    cmd("oper cond long", "stat:oper:cond?\n", dec(rnd));
    cmd("oper event", "STATus:OPERation:EVENt?\n", dec(rnd));
    cmd("oper event cleared", "s:o?\n", dec(16'h0000));
    $display("test operation queries done");

    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      v = (i == 3) ? ENABLE_MAX : (rnd & ENABLE_MAX);
      slow <= rnd[0];
      cmd("oper enab set", $sformatf("S:O:ENAB %0d\n", v), chr(CHAR_ACK));
      cmd("oper enab query", "S:O:ENAB?\n", dec(v));
      cmd("ques enab set", $sformatf("s:q:enab %0d\n", v), chr(CHAR_ACK));
      cmd("ques enab query", "S:Q:ENAB?\n", dec(v));
    end
    slow <= 1'b0;
    $display("test enable registers done");

    cmd("enab over", "S:O:ENAB 32768\n", chr(CHAR_NAK));
    chk8("esr cmd err", 8'h20, std_ev);
    cmd("enab missing", "S:O:ENAB\n", chr(CHAR_NAK));
    cmd("enab kept", "S:O:ENAB?\n", dec(ENABLE_MAX));
    cmd("bad header", "X:Y?\n", chr(CHAR_NAK));
    cmd("event as setting", "S:O:E\n", chr(CHAR_NAK));
    esr_en <= 8'h20;
    settle;
    chk8("stb esb", 8'h20, stb);
    srq_en <= 8'h20;
    settle;
    chk8("stb esb srq", 8'h60, stb);
    chk8("srq esb", 8'h01, {7'h00, srq});
    pulse_cls;
    chk8("esr cleared", 8'h00, std_ev);
    chk8("stb cleared", 8'h00, stb);
    esr_en <= 8'h00;
    esr_ev <= 8'h01;
    @(posedge clk_i);
    esr_ev <= 8'h00;
    settle;
    chk8("esr event", 8'h01, std_ev);
    chk8("stb disabled", 8'h00, stb);
    pulse_cls;
    $display("test errors and standard events done");

    cmd("preset", "S:PRES\n", chr(CHAR_ACK));
    cmd("oper enab preset", "S:O:ENAB?\n", dec(16'h0000));
    cmd("ques enab preset", "S:Q:ENAB?\n", dec(16'h0000));
    $display("test preset done");

    cmd("oper enab pon", "S:O:ENAB 512\n", chr(CHAR_ACK));
    chk8("stb no oper", 8'h00, stb);
    @(posedge clk_i);
    power_on_flag <= 1'b1;
    @(posedge clk_i);
    power_on_flag <= 1'b0;
    settle;
    chk8("stb oper", 8'h80, stb);
    srq_en <= 8'h80;
    settle;
    chk8("stb oper srq", 8'hC0, stb);
    cmd("pon event", "S:O:E?\n", dec(16'h0200));
    chk8("stb pon read", 8'h00, stb);
    $display("test operation summary done");

    cmd("ques enab warn", "S:Q:ENAB 16384\n", chr(CHAR_ACK));
    rnd = lfsr_next(rnd);
    v = rnd & 16'h3FFF;
    ques_cond <= v;
    srq_en <= 8'h08;
    settle;
    cmd("ques cond", "S:Q:C?\n", dec(v));
    chk8("stb no ques", 8'h00, stb);
    cmd("stray param", "S:Q:C? 7\n", dec(v));
    chk8("stb ques srq", 8'h48, stb);
    chk8("esr no error", 8'h00, std_ev);
    cmd("ques event", "S:Q:E?\n", dec(v | 16'h4000));
    chk8("stb ques read", 8'h00, stb);
    $display("test questionable summary done");

    busy <= 1'b1;
    settle;
    chk8("stb mav", 8'h10, stb);
    busy <= 1'b0;
    settle;
    chk8("stb mav clear", 8'h00, stb);
    $display("test message available done");

    rnd = lfsr_next(rnd);
    fres <= rnd[7:0];
    settle;
    cmd("fault query", "S:Q:F?\n", $sformatf("%02X\n", rnd[7:0]));
    $display("test resistance faults done");
    tally_and_finish;
  end
endmodule
